// file: design/sau_core.sv
// saturating arithmetic datapath with sticky saturation flag
`timescale 1ns/10ps
module sau_core
    import sau_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        OP_VALID,
    input  wire sau_op_t     OP_CODE,
    input  wire logic        COND_PASS,
    input  wire logic [31:0] SRC_A,
    input  wire logic [31:0] SRC_B,
    input  wire logic [5:0]  SAT_WIDTH,
    input  wire logic        SHIFT_ARITH,
    input  wire logic [4:0]  SHIFT_AMT,
    input  wire logic        STATUS_WR,
    input  wire logic        STATUS_WR_SAT,
    output logic      [31:0] RESULT,
    output logic             RESULT_WE,
    output logic             SAT_FLAG,
    output logic             COND_FLAGS_WE
);

    //------------------------------------------------------------
    // lane signals
    //------------------------------------------------------------
    logic signed [WIDE_W-1:0] w_val;
    logic signed [WIDE_W-1:0] w_res;
    logic                     w_sat;
    logic        [5:0]        w_n;
    logic                     w_uns;
    logic signed [DBL_W-1:0]  d_val;
    logic signed [DBL_W-1:0]  d_res;
    logic                     d_sat;
    logic signed [WIDE_W-1:0] shifted;
    logic signed [WIDE_W-1:0] dbl_ext;

    logic signed [17:0] h_val [2];
    logic signed [17:0] h_res [2];
    logic               h_sat [2];
    logic        [5:0]  h_n;
    logic               h_uns;
    logic signed [9:0]  b_val [4];
    logic signed [9:0]  b_res [4];
    logic               b_sat [4];
    logic               b_uns;

    logic [15:0] a_h  [2];
    logic [15:0] b_h  [2];
    logic [15:0] bx_h [2];
    logic [7:0]  a_b  [4];
    logic [7:0]  b_b  [4];

    logic [31:0] op_res;
    logic        op_sat;
    logic        n_ok;

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    logic [31:0] result_reg;
    logic [31:0] result_next;
    logic        result_we_reg;
    logic        result_we_next;
    logic        sat_flag_reg;
    logic        sat_flag_next;

    //------------------------------------------------------------
    // clamp lanes
    //------------------------------------------------------------
    sau_lane_clamp #(.IW(WIDE_W)) u_word (
        .val (w_val),
        .n   (w_n),
        .uns (w_uns),
        .res (w_res),
        .sat (w_sat)
    );

    sau_lane_clamp #(.IW(DBL_W)) u_dbl (
        .val (d_val),
        .n   (N_WORD),
        .uns (1'b0),
        .res (d_res),
        .sat (d_sat)
    );

    for (genvar i = 0; i < 2; i++) begin : g_half
        sau_lane_clamp #(.IW(18)) u_half (
            .val (h_val[i]),
            .n   (h_n),
            .uns (h_uns),
            .res (h_res[i]),
            .sat (h_sat[i])
        );
    end

    for (genvar i = 0; i < 4; i++) begin : g_byte
        sau_lane_clamp #(.IW(10)) u_byte (
            .val (b_val[i]),
            .n   (N_BYTE),
            .uns (b_uns),
            .res (b_res[i]),
            .sat (b_sat[i])
        );
    end

    //------------------------------------------------------------
    // operand split and word-lane inputs
    //------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            a_h[i]  = SRC_A[HALF_W*i +: HALF_W];
            b_h[i]  = SRC_B[HALF_W*i +: HALF_W];
            bx_h[i] = SRC_B[HALF_W*(1-i) +: HALF_W];
        end
        for (int i = 0; i < 4; i++) begin
            a_b[i] = SRC_A[BYTE_W*i +: BYTE_W];
            b_b[i] = SRC_B[BYTE_W*i +: BYTE_W];
        end
        // pre-shift; amount zero leaves the source as is
        if (SHIFT_ARITH) begin
            shifted = WIDE_W'($signed(SRC_B)) >>> SHIFT_AMT;
        end else begin
            shifted = WIDE_W'($signed(SRC_B)) <<< SHIFT_AMT;
        end
        // doubling saturates on its own before the add
        d_val   = DBL_W'($signed(SRC_B)) <<< 1;
        dbl_ext = WIDE_W'($signed(d_res[31:0]));
        w_n     = N_WORD;
        w_uns   = 1'b0;
        w_val   = shifted;
        unique case (OP_CODE)
            OP_SIGNED_WIDTH_CLAMP: w_n = SAT_WIDTH;
            OP_UNSIGNED_WIDTH_CLAMP: begin
                w_n   = SAT_WIDTH;
                w_uns = 1'b1;
            end
            OP_SIGNED_SAT_ADD_WORD: begin
                w_val = WIDE_W'($signed(SRC_A)) + WIDE_W'($signed(SRC_B));
            end
            OP_SIGNED_SAT_SUB_WORD: begin
                w_val = WIDE_W'($signed(SRC_A)) - WIDE_W'($signed(SRC_B));
            end
            OP_SIGNED_DOUBLE_THEN_ADD: w_val = WIDE_W'($signed(SRC_A)) + dbl_ext;
            OP_SIGNED_DOUBLE_THEN_SUB: w_val = WIDE_W'($signed(SRC_A)) - dbl_ext;
            default:                   w_val = shifted;
        endcase
    end

    //------------------------------------------------------------
    // halfword and byte lane inputs
    //------------------------------------------------------------
    always_comb begin
        h_n   = N_HALF;
        h_uns = 1'b0;
        b_uns = 1'b0;
        for (int i = 0; i < 2; i++) begin
            h_val[i] = 18'($signed(b_h[i]));
        end
        for (int i = 0; i < 4; i++) begin
            b_val[i] = 10'($signed(a_b[i])) + 10'($signed(b_b[i]));
        end
        unique case (OP_CODE)
            OP_SIGNED_HALFWORD_CLAMP: h_n = SAT_WIDTH;
            OP_UNSIGNED_HALFWORD_CLAMP: begin
                h_n   = SAT_WIDTH;
                h_uns = 1'b1;
            end
            OP_SIGNED_SAT_ADD_HALVES: begin
                for (int i = 0; i < 2; i++) begin
                    h_val[i] = 18'($signed(a_h[i])) + 18'($signed(b_h[i]));
                end
            end
            OP_SIGNED_SAT_SUB_HALVES: begin
                for (int i = 0; i < 2; i++) begin
                    h_val[i] = 18'($signed(a_h[i])) - 18'($signed(b_h[i]));
                end
            end
            OP_UNSIGNED_SAT_ADD_HALVES: begin
                h_n   = N_HALF;
                h_uns = 1'b1;
                for (int i = 0; i < 2; i++) begin
                    h_val[i] = 18'(a_h[i]) + 18'(b_h[i]);
                end
            end
            OP_UNSIGNED_SAT_SUB_HALVES: begin
                h_uns = 1'b1;
                for (int i = 0; i < 2; i++) begin
                    h_val[i] = 18'(a_h[i]) - 18'(b_h[i]);
                end
            end
            OP_SIGNED_ADD_SUB_EXCHANGE: begin
                // top lane adds, bottom lane subtracts, second operand crossed
                h_val[1] = 18'($signed(a_h[1])) + 18'($signed(bx_h[1]));
                h_val[0] = 18'($signed(a_h[0])) - 18'($signed(bx_h[0]));
            end
            OP_SIGNED_SUB_ADD_EXCHANGE: begin
                h_val[1] = 18'($signed(a_h[1])) - 18'($signed(bx_h[1]));
                h_val[0] = 18'($signed(a_h[0])) + 18'($signed(bx_h[0]));
            end
            OP_UNSIGNED_ADD_SUB_EXCHANGE: begin
                h_uns    = 1'b1;
                h_val[1] = 18'(a_h[1]) + 18'(bx_h[1]);
                h_val[0] = 18'(a_h[0]) - 18'(bx_h[0]);
            end
            OP_UNSIGNED_SUB_ADD_EXCHANGE: begin
                h_uns    = 1'b1;
                h_val[1] = 18'(a_h[1]) - 18'(bx_h[1]);
                h_val[0] = 18'(a_h[0]) + 18'(bx_h[0]);
            end
            OP_SIGNED_SAT_SUB_BYTES: begin
                for (int i = 0; i < 4; i++) begin
                    b_val[i] = 10'($signed(a_b[i])) - 10'($signed(b_b[i]));
                end
            end
            OP_UNSIGNED_SAT_ADD_BYTES: begin
                b_uns = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    b_val[i] = 10'(a_b[i]) + 10'(b_b[i]);
                end
            end
            OP_UNSIGNED_SAT_SUB_BYTES: begin
                b_uns = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    b_val[i] = 10'(a_b[i]) - 10'(b_b[i]);
                end
            end
            default: h_n = N_HALF;
        endcase
    end

    //------------------------------------------------------------
    // result select, flag source and width check
    //------------------------------------------------------------
    always_comb begin
        op_res = w_res[31:0];
        op_sat = 1'b0;
        n_ok   = 1'b1;
        unique case (OP_CODE)
            OP_SIGNED_WIDTH_CLAMP: begin
                op_sat = w_sat;
                n_ok   = (SAT_WIDTH >= SWC_N_MIN) && (SAT_WIDTH <= SWC_N_MAX);
            end
            OP_UNSIGNED_WIDTH_CLAMP: begin
                op_sat = w_sat;
                n_ok   = (SAT_WIDTH <= UWC_N_MAX);
            end
            OP_SIGNED_SAT_ADD_WORD,
            OP_SIGNED_SAT_SUB_WORD:    op_sat = w_sat;
            OP_SIGNED_DOUBLE_THEN_ADD,
            OP_SIGNED_DOUBLE_THEN_SUB: op_sat = w_sat | d_sat;
            OP_SIGNED_HALFWORD_CLAMP,
            OP_UNSIGNED_HALFWORD_CLAMP: begin
                op_res = {h_res[1][15:0], h_res[0][15:0]};
                op_sat = h_sat[1] | h_sat[0];
                if (OP_CODE == OP_SIGNED_HALFWORD_CLAMP) begin
                    n_ok = (SAT_WIDTH >= SHC_N_MIN) && (SAT_WIDTH <= SHC_N_MAX);
                end else begin
                    n_ok = (SAT_WIDTH <= UHC_N_MAX);
                end
            end
            OP_SIGNED_SAT_ADD_HALVES,
            OP_SIGNED_SAT_SUB_HALVES,
            OP_UNSIGNED_SAT_ADD_HALVES,
            OP_UNSIGNED_SAT_SUB_HALVES,
            OP_SIGNED_ADD_SUB_EXCHANGE,
            OP_SIGNED_SUB_ADD_EXCHANGE,
            OP_UNSIGNED_ADD_SUB_EXCHANGE,
            OP_UNSIGNED_SUB_ADD_EXCHANGE: begin
                op_res = {h_res[1][15:0], h_res[0][15:0]};
                op_sat = 1'b0;
            end
            OP_SIGNED_SAT_ADD_BYTES,
            OP_SIGNED_SAT_SUB_BYTES,
            OP_UNSIGNED_SAT_ADD_BYTES,
            OP_UNSIGNED_SAT_SUB_BYTES: begin
                op_res = {b_res[3][7:0], b_res[2][7:0], b_res[1][7:0], b_res[0][7:0]};
                op_sat = 1'b0;
            end
            default: n_ok = 1'b0;
        endcase
    end

    //------------------------------------------------------------
    // result and sticky flag state
    //------------------------------------------------------------
    always_comb begin
        result_next    = result_reg;
        result_we_next = 1'b0;
        sat_flag_next  = sat_flag_reg;
        if (STATUS_WR) begin
            sat_flag_next = STATUS_WR_SAT;
        end
        // a failed condition writes nothing and leaves the flag
        if (OP_VALID && COND_PASS && n_ok) begin
            result_next    = op_res;
            result_we_next = 1'b1;
            if (op_sat) begin
                sat_flag_next = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            result_reg    <= RESULT_RST;
            result_we_reg <= 1'b0;
            sat_flag_reg  <= FLAG_RST;
        end else begin
            result_reg    <= result_next;
            result_we_reg <= result_we_next;
            sat_flag_reg  <= sat_flag_next;
        end
    end

    assign RESULT        = result_reg;
    assign RESULT_WE     = result_we_reg;
    assign SAT_FLAG      = sat_flag_reg;
    assign COND_FLAGS_WE = 1'b0;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    logic take_now;
    assign take_now = OP_VALID && COND_PASS;
    sclamp_range_a: assert property (
        take_now && OP_CODE == OP_SIGNED_WIDTH_CLAMP && SAT_WIDTH == 6'h08
        |=> RESULT_WE && ($signed(RESULT) <= 32'sd127) && ($signed(RESULT) >= -32'sd128))
        else $error("signed clamp out of range");
    uns_neg_zero_a: assert property (
        take_now && OP_CODE == OP_UNSIGNED_WIDTH_CLAMP && SRC_B[31]
        && SHIFT_AMT == 5'h00 && SAT_WIDTH <= UWC_N_MAX
        |=> RESULT == 32'h0000_0000)
        else $error("negative unsigned clamp not zero");
    uclamp_range_a: assert property (
        take_now && OP_CODE == OP_UNSIGNED_WIDTH_CLAMP && SAT_WIDTH == 6'h08
        |=> RESULT_WE && RESULT <= 32'h0000_00ff)
        else $error("unsigned clamp out of range");
    word_sat_flag_a: assert property (
        take_now && OP_CODE == OP_SIGNED_SAT_ADD_WORD && !SRC_A[31] && !SRC_B[31]
        && (SRC_A + SRC_B) >= 32'h8000_0000
        |=> SAT_FLAG && RESULT == 32'h7fff_ffff)
        else $error("word add overflow not flagged");
    flag_hold_a: assert property (
        SAT_FLAG && !STATUS_WR |=> SAT_FLAG [*1] ##1 1'b1)
        else $error("sticky flag dropped without write");
    flag_clear_a: assert property (
        $fell(SAT_FLAG) |-> $past(STATUS_WR) && !$past(STATUS_WR_SAT))
        else $error("sticky flag cleared without status write");
    lane_no_flag_a: assert property (
        !SAT_FLAG && !STATUS_WR && OP_VALID && OP_CODE == OP_SIGNED_SAT_ADD_BYTES
        |=> !SAT_FLAG)
        else $error("byte lane add touched sticky flag");
    cond_fail_a: assert property (
        OP_VALID && !COND_PASS && !STATUS_WR
        |=> !RESULT_WE && $stable(SAT_FLAG) && $stable(RESULT))
        else $error("failed condition changed state");
    cover_word_sat: cover property (
        take_now && OP_CODE == OP_SIGNED_WIDTH_CLAMP ##1 $rose(SAT_FLAG));
    cover_half_op: cover property (
        take_now && OP_CODE == OP_SIGNED_ADD_SUB_EXCHANGE ##1 RESULT_WE);
    cover_flag_clear: cover property (
        SAT_FLAG ##1 STATUS_WR && !STATUS_WR_SAT ##1 !SAT_FLAG);

endmodule

// file: design/sau_lane_clamp.sv
// one saturating clamp lane: signed n-bit or unsigned n-bit range
`timescale 1ns/10ps
module sau_lane_clamp
    import sau_pkg::*;
#(
    parameter int IW = 18
) (
    input  wire logic signed [IW-1:0] val,
    input  wire logic        [5:0]    n,
    input  wire logic                 uns,
    output logic signed      [IW-1:0] res,
    output logic                      sat
);

    logic signed [IW:0] hi;
    logic signed [IW:0] lo;
    logic signed [IW:0] v;

    always_comb begin
        v = {val[IW-1], val};
        // unsigned top of range is 2^n-1, signed top is 2^(n-1)-1
        if (uns) begin
            hi = ((IW+1)'(1) << n) - (IW+1)'(1);
            lo = '0;
        end else begin
            hi = ((IW+1)'(1) << (n - 6'h01)) - (IW+1)'(1);
            lo = ~hi;
        end
        if (v > hi) begin
            res = hi[IW-1:0];
            sat = 1'b1;
        end else if (v < lo) begin
            res = lo[IW-1:0];
            sat = 1'b1;
        end else begin
            res = val;
            sat = 1'b0;
        end
    end

endmodule

// file: design/sau_pkg.sv
// constants and operation codes for the saturating arithmetic unit
//------------------------------------------------------------------
// What this block does
//------------------------------------------------------------------
package sau_pkg;

    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int WIDE_W = 64;
    localparam int DBL_W  = 34;

    localparam logic [5:0] SWC_N_MIN  = 6'h01;
    localparam logic [5:0] SWC_N_MAX  = 6'h20;
    localparam logic [5:0] UWC_N_MAX  = 6'h1f;
    localparam logic [5:0] SHC_N_MIN  = 6'h01;
    localparam logic [5:0] SHC_N_MAX  = 6'h10;
    localparam logic [5:0] UHC_N_MAX  = 6'h0f;
    localparam logic [5:0] N_WORD     = 6'h20;
    localparam logic [5:0] N_HALF     = 6'h10;
    localparam logic [5:0] N_BYTE     = 6'h08;

    localparam logic        FLAG_RST   = 1'h0;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;

    typedef enum logic [4:0] {
        OP_SIGNED_WIDTH_CLAMP,
        OP_UNSIGNED_WIDTH_CLAMP,
        OP_SIGNED_HALFWORD_CLAMP,
        OP_UNSIGNED_HALFWORD_CLAMP,
        OP_SIGNED_SAT_ADD_WORD,
        OP_SIGNED_SAT_SUB_WORD,
        OP_SIGNED_SAT_ADD_HALVES,
        OP_SIGNED_SAT_SUB_HALVES,
        OP_SIGNED_SAT_ADD_BYTES,
        OP_SIGNED_SAT_SUB_BYTES,
        OP_SIGNED_ADD_SUB_EXCHANGE,
        OP_SIGNED_SUB_ADD_EXCHANGE,
        OP_SIGNED_DOUBLE_THEN_ADD,
        OP_SIGNED_DOUBLE_THEN_SUB,
        OP_UNSIGNED_SAT_ADD_HALVES,
        OP_UNSIGNED_SAT_SUB_HALVES,
        OP_UNSIGNED_SAT_ADD_BYTES,
        OP_UNSIGNED_SAT_SUB_BYTES,
        OP_UNSIGNED_ADD_SUB_EXCHANGE,
        OP_UNSIGNED_SUB_ADD_EXCHANGE
    } sau_op_t;

endpackage

// file: testbench/sau_regfile_model.sv
// register file model: takes each result the unit hands back
`timescale 1ns/10ps
module sau_regfile_model
    import sau_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] result,
    input  wire logic        result_we,
    output logic      [31:0] dest_reg,
    output logic      [15:0] wr_cnt_reg
);
    logic [31:0] dest_next;
    logic [15:0] wr_cnt_next;

    // the destination changes only on a write strobe
    always_comb begin
        dest_next   = dest_reg;
        wr_cnt_next = wr_cnt_reg;
        if (result_we) begin
            dest_next   = result;
            wr_cnt_next = wr_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dest_reg   <= 32'h0000_0000;
            wr_cnt_reg <= 16'h0000;
        end else begin
            dest_reg   <= dest_next;
            wr_cnt_reg <= wr_cnt_next;
        end
    end
endmodule

// file: testbench/tb_sau_core.sv
// self-checking bench for the saturating arithmetic unit
`timescale 1ns/10ps
module tb_sau_core
    import sau_pkg::*;
;
    logic        CORE_CLK, RST_N, OP_VALID, COND_PASS, SHIFT_ARITH, STATUS_WR, STATUS_WR_SAT;
    sau_op_t     OP_CODE;
    logic [31:0] SRC_A, SRC_B, RESULT, dest_val, last_res;
    logic [5:0]  SAT_WIDTH;
    logic [4:0]  SHIFT_AMT;
    logic        RESULT_WE, SAT_FLAG, COND_FLAGS_WE;
    logic [15:0] wr_cnt, cnt_before;
    int          err_total, checks;
    sau_op_t     rc [5];
    logic [5:0]  rn [5];

    sau_core u_sau_core (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID),
        .OP_CODE(OP_CODE), .COND_PASS(COND_PASS), .SRC_A(SRC_A), .SRC_B(SRC_B),
        .SAT_WIDTH(SAT_WIDTH), .SHIFT_ARITH(SHIFT_ARITH), .SHIFT_AMT(SHIFT_AMT),
        .STATUS_WR(STATUS_WR), .STATUS_WR_SAT(STATUS_WR_SAT), .RESULT(RESULT),
        .RESULT_WE(RESULT_WE), .SAT_FLAG(SAT_FLAG), .COND_FLAGS_WE(COND_FLAGS_WE));

    sau_regfile_model u_sau_regfile_model (.clk(CORE_CLK), .rst_n(RST_N), .result(RESULT),
        .result_we(RESULT_WE), .dest_reg(dest_val), .wr_cnt_reg(wr_cnt));

    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // present one operation, then look at the answer one edge later
    task automatic op(input sau_op_t c, input logic [31:0] a, input logic [31:0] b,
                      input logic [5:0] n, input logic [31:0] exp, input logic f,
                      input logic we);
        OP_VALID  = 1'b1;
        OP_CODE   = c;
        SRC_A     = a;
        SRC_B     = b;
        SAT_WIDTH = n;
        @(posedge CORE_CLK);
        #1;
        if (we)
            last_res = exp;
        chk("result_we", {31'h0, RESULT_WE}, {31'h0, we});
        chk("result", RESULT, last_res);
        chk("sat_flag", {31'h0, SAT_FLAG}, {31'h0, f});
        chk("cond_flags_we", {31'h0, COND_FLAGS_WE}, 32'h0);
    endtask

    task automatic stat(input logic v);
        OP_VALID      = 1'b0;
        STATUS_WR     = 1'b1;
        STATUS_WR_SAT = v;
        @(posedge CORE_CLK);
        #1;
        chk("sat_flag_write", {31'h0, SAT_FLAG}, {31'h0, v});
        STATUS_WR = 1'b0;
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_total++;
        conclude();
    end

    initial begin
        {RST_N, OP_VALID, STATUS_WR, STATUS_WR_SAT, SHIFT_ARITH} = 5'h00;
        COND_PASS = 1'b1;
        OP_CODE   = OP_SIGNED_WIDTH_CLAMP;
        {SRC_A, SRC_B, last_res} = {32'h0, 32'h0, 32'h0};
        SAT_WIDTH = 6'h00;
        SHIFT_AMT = 5'h00;
        err_total = 0;
        checks    = 0;
        repeat (2) @(posedge CORE_CLK);
        #1;
        RST_N = 1'b1;
        chk("reset_flag", {31'h0, SAT_FLAG}, 32'h0);
        //----------------------------------------------------------
        // word clamps, widths and pre-shifts
        //----------------------------------------------------------
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h0000_012c, 6'h08, 32'h0000_007f, 1, 1);
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h0000_0005, 6'h08, 32'h0000_0005, 1, 1);
        stat(1'b0);
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h8000_0000, 6'h20, 32'h8000_0000, 0, 1);
        op(OP_UNSIGNED_WIDTH_CLAMP, 0, 32'h7fff_ffff, 6'h1f, 32'h7fff_ffff, 0, 1);
        op(OP_UNSIGNED_WIDTH_CLAMP, 0, 32'h0000_0000, 6'h00, 32'h0000_0000, 0, 1);
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h0000_0001, 6'h01, 32'h0000_0000, 1, 1);
        op(OP_UNSIGNED_WIDTH_CLAMP, 0, 32'hffff_fffb, 6'h08, 32'h0000_0000, 1, 1);
        stat(1'b0);
        SHIFT_AMT = 5'h04;
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h0000_0100, 6'h10, 32'h0000_1000, 0, 1);
        SHIFT_ARITH = 1'b1;
        SHIFT_AMT   = 5'h1f;
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h8000_0000, 6'h20, 32'hffff_ffff, 0, 1);
        op(OP_UNSIGNED_WIDTH_CLAMP, 0, 32'h8000_0000, 6'h04, 32'h0000_0000, 1, 1);
        SHIFT_ARITH = 1'b0;
        op(OP_SIGNED_WIDTH_CLAMP, 0, 32'h0000_0001, 6'h20, 32'h7fff_ffff, 1, 1);
        SHIFT_AMT = 5'h00;
        stat(1'b0);
        done("word_clamp");
        //----------------------------------------------------------
        // halfword clamps
        //----------------------------------------------------------
        op(OP_SIGNED_HALFWORD_CLAMP, 0, 32'h8000_7fff, 6'h10, 32'h8000_7fff, 0, 1);
        op(OP_UNSIGNED_HALFWORD_CLAMP, 0, 32'h7fff_0005, 6'h0f, 32'h7fff_0005, 0, 1);
        op(OP_SIGNED_HALFWORD_CLAMP, 0, 32'h8000_7000, 6'h09, 32'hff00_00ff, 1, 1);
        stat(1'b0);
        op(OP_UNSIGNED_HALFWORD_CLAMP, 0, 32'h7fff_ffff, 6'h0f, 32'h7fff_0000, 1, 1);
        stat(1'b0);
        done("half_clamp");
        //----------------------------------------------------------
        // lane arithmetic, flag untouched
        //----------------------------------------------------------
        op(OP_SIGNED_SAT_ADD_HALVES, 32'h7fff_8000, 32'h0001_ffff, 0, 32'h7fff_8000, 0, 1);
        op(OP_SIGNED_SAT_SUB_HALVES, 32'h8000_7fff, 32'h0001_ffff, 0, 32'h8000_7fff, 0, 1);
        op(OP_SIGNED_SAT_ADD_BYTES, 32'h7f80_0102, 32'h01ff_0203, 0, 32'h7f80_0305, 0, 1);
        op(OP_SIGNED_SAT_SUB_BYTES, 32'h807f_1000, 32'h01ff_0801, 0, 32'h807f_08ff, 0, 1);
        op(OP_SIGNED_ADD_SUB_EXCHANGE, 32'h7fff_8000, 32'h8000_0001, 0, 32'h7fff_0000, 0, 1);
        op(OP_SIGNED_SUB_ADD_EXCHANGE, 32'h7fff_8000, 32'h8000_0001, 0, 32'h7ffe_8000, 0, 1);
        op(OP_UNSIGNED_ADD_SUB_EXCHANGE, 32'hffff_0001, 32'h0002_0001, 0, 32'hffff_0000, 0, 1);
        op(OP_UNSIGNED_SUB_ADD_EXCHANGE, 32'hffff_0001, 32'h0002_0001, 0, 32'hfffe_0003, 0, 1);
        op(OP_UNSIGNED_SAT_ADD_HALVES, 32'hfff0_0001, 32'h0020_0002, 0, 32'hffff_0003, 0, 1);
        op(OP_UNSIGNED_SAT_SUB_HALVES, 32'h0001_0005, 32'h0002_0003, 0, 32'h0000_0002, 0, 1);
        op(OP_UNSIGNED_SAT_ADD_BYTES, 32'hff01_8000, 32'h0101_8001, 0, 32'hff02_ff01, 0, 1);
        op(OP_UNSIGNED_SAT_SUB_BYTES, 32'h0010_2005, 32'h0108_3001, 0, 32'h0008_0004, 0, 1);
        done("lanes");
        //----------------------------------------------------------
        // word add, subtract and doubling forms
        //----------------------------------------------------------
        op(OP_SIGNED_SAT_SUB_WORD, 32'h0000_0005, 32'h0000_0007, 0, 32'hffff_fffe, 0, 1);
        op(OP_SIGNED_DOUBLE_THEN_SUB, 0, 32'h2000_0000, 0, 32'hc000_0000, 0, 1);
        op(OP_SIGNED_DOUBLE_THEN_ADD, 32'hc000_0000, 32'h4000_0000, 0, 32'h3fff_ffff, 1, 1);
        stat(1'b0);
        op(OP_SIGNED_SAT_ADD_WORD, 32'h7fff_ffff, 32'h0000_0001, 0, 32'h7fff_ffff, 1, 1);
        stat(1'b0);
        STATUS_WR     = 1'b1;
        STATUS_WR_SAT = 1'b0;
        op(OP_SIGNED_SAT_SUB_WORD, 32'h8000_0000, 32'h0000_0001, 0, 32'h8000_0000, 1, 1);
        STATUS_WR = 1'b0;
        stat(1'b0);
        done("word_arith");
        //----------------------------------------------------------
        // refused operations leave result, flag and destination alone
        //----------------------------------------------------------
        cnt_before = wr_cnt;
        rc = '{OP_SIGNED_WIDTH_CLAMP, OP_SIGNED_WIDTH_CLAMP, OP_UNSIGNED_WIDTH_CLAMP,
               OP_SIGNED_HALFWORD_CLAMP, OP_UNSIGNED_HALFWORD_CLAMP};
        rn = '{6'h00, 6'h21, 6'h20, 6'h11, 6'h10};
        for (int i = 0; i < 5; i++) begin
            op(rc[i], 0, 32'h7fff_8000, rn[i], 0, 0, 0);
        end
        op(sau_op_t'(5'h1f), 32'h7fff_ffff, 32'h0000_0001, 0, 0, 0, 0);
        COND_PASS = 1'b0;
        op(OP_SIGNED_SAT_ADD_WORD, 32'h7fff_ffff, 32'h0000_0001, 0, 0, 0, 0);
        COND_PASS = 1'b1;
        stat(1'b0);
        chk("dest_writes", {16'h0, wr_cnt}, {16'h0, cnt_before});
        chk("dest_value", dest_val, last_res);
        stat(1'b1);
        done("refused");
        conclude();
    end
endmodule
